/* File: hdl/acio_port.v */
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "acio_defines.vh"
module acio_port #(
    parameter PINS = 8,
    parameter ADDR_W = 18
) (
    input wire aclk,
    input wire aresetn,
    // Chip operating mode and power state
    input wire [2:0] mode,
    input wire hw_standby,
    input wire manual_reset,
    input wire sw_standby,
    // Address value from the external bus controller
    input wire [PINS-1:0] addr_bus,
    // Pins
    input wire [PINS-1:0] pin_in,
    output wire [PINS-1:0] pin_out,
    output wire [PINS-1:0] pin_oe,
    output wire [PINS-1:0] pullup_en,
    // AXI4-Lite write address
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    reg [PINS-1:0] pin_direction_q;
    reg [PINS-1:0] output_data_q;
    reg [PINS-1:0] pullup_control_q;
    reg standby_output_hold_enable_q;
    reg [PINS-1:0] readback_q;
    reg [PINS-1:0] readback_d;
    reg [PINS-1:0] addr_hold_q;
    reg sw_standby_q;

    reg aw_full_q;
    reg [15:0] aw_idx_q;
    reg w_full_q;
    reg [PINS-1:0] w_data_q;
    reg w_lane_q;
    reg bvalid_q;
    reg [1:0] bresp_q;
    reg rvalid_q;
    reg [31:0] rdata_q;
    reg [1:0] rresp_q;

    reg [31:0] rd_word;
    reg rd_hit;
    reg wr_hit;

    reg cls_fixed;
    reg cls_sel;
    reg cls_gpio;
    reg pu_allowed;

    wire [PINS-1:0] pin_sync;
    wire [PINS-1:0] addr_src;
    wire wr_fire;
    wire rd_fire;
    wire retain;
    wire [15:0] ar_idx;

    // ------------------------------------------------------------------
    // Power state
    // ------------------------------------------------------------------

    // Manual reset and software standby freeze the readback register, except during hardware standby
    assign retain = manual_reset | sw_standby;

    // Delayed standby flag, keeps the held address one cycle past standby exit
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sw_standby_q <= 1'b0;
        end
        else
        begin
            sw_standby_q <= sw_standby;
        end
    end

    // Address latched while running, frozen once standby is entered
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            addr_hold_q <= {PINS{1'b0}};
        end
        else if (!sw_standby)
        begin
            addr_hold_q <= addr_bus;
        end
    end

    // Live address while running, held value during standby
    assign addr_src = (sw_standby | sw_standby_q) ? addr_hold_q : addr_bus;

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------

    // Classify the operating mode for all pins
    always @*
    begin
        cls_fixed = 1'b0;
        cls_sel = 1'b0;
        cls_gpio = 1'b0;
        pu_allowed = 1'b0;
        case (mode)
            `ACIO_MODE_1, `ACIO_MODE_4, `ACIO_MODE_5:
            begin
                cls_fixed = 1'b1;
            end
            `ACIO_MODE_2, `ACIO_MODE_6:
            begin
                cls_sel = 1'b1;
                pu_allowed = 1'b1;
            end
            `ACIO_MODE_3, `ACIO_MODE_7:
            begin
                cls_gpio = 1'b1;
                pu_allowed = 1'b1;
            end
            default:
            begin
                cls_gpio = 1'b0; // Unused mode: every pin an input
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Pin cells
    // ------------------------------------------------------------------

    // One steering cell per pin
    genvar gi;
    generate
        for (gi = 0; gi < PINS; gi = gi + 1)
        begin : g_pin
            acio_pin_cell u_cell (
                .aclk(aclk),
                .aresetn(aresetn),
                .cls_fixed(cls_fixed),
                .cls_sel(cls_sel),
                .cls_gpio(cls_gpio),
                .pu_allowed(pu_allowed),
                .dir_bit(pin_direction_q[gi]),
                .data_bit(output_data_q[gi]),
                .pullup_bit(pullup_control_q[gi]),
                .addr_bit(addr_src[gi]),
                .sw_standby(sw_standby),
                .hold_en(standby_output_hold_enable_q),
                .hw_standby(hw_standby),
                .pin_out(pin_out[gi]),
                .pin_oe(pin_oe[gi]),
                .pullup_en(pullup_en[gi])
            );
        end
    endgenerate

    // Pin levels brought into the clock domain
    acio_sync #(
        .WIDTH(PINS)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(pin_in),
        .sync_out(pin_sync)
    );

    // ------------------------------------------------------------------
    // Readback
    // ------------------------------------------------------------------

    // Per bit: output data if an output, sampled pin otherwise
    always @*
    begin
        readback_d = (pin_direction_q & output_data_q)
            | (~pin_direction_q & pin_sync);
    end

    // Tracks the pins, frozen through manual reset and software standby except in hardware standby
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            readback_q <= {PINS{1'b0}};
        end
        else if (hw_standby || !retain)
        begin
            readback_q <= readback_d;
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------------

    assign s_axi_awready = !aw_full_q && !bvalid_q;
    assign s_axi_wready = !w_full_q && !bvalid_q;
    assign wr_fire = aw_full_q && w_full_q && !bvalid_q;

    // Address and data latched independently, in either order
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_q <= 1'b0;
            aw_idx_q <= 16'h0000;
            w_full_q <= 1'b0;
            w_data_q <= {PINS{1'b0}};
            w_lane_q <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_full_q <= 1'b1;
                aw_idx_q <= s_axi_awaddr[`ACIO_IDX_MSB:`ACIO_IDX_LSB];
            end
            else if (wr_fire)
            begin
                aw_full_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_full_q <= 1'b1;
                w_data_q <= s_axi_wdata[PINS-1:0];
                w_lane_q <= s_axi_wstrb[`ACIO_DATA_LANE];
            end
            else if (wr_fire)
            begin
                w_full_q <= 1'b0;
            end
        end
    end

    // Write decode; readback index accepted but stores nothing
    always @*
    begin
        case (aw_idx_q)
            `ACIO_IDX_DIR, `ACIO_IDX_DATA, `ACIO_IDX_PULLUP,
            `ACIO_IDX_STBY, `ACIO_IDX_READBACK:
            begin
                wr_hit = 1'b1;
            end
            default:
            begin
                wr_hit = 1'b0;
            end
        endcase
    end

    // Control registers: cleared by reset and hardware standby
    always @(posedge aclk)
    begin
        if (!aresetn || hw_standby)
        begin
            pin_direction_q <= `ACIO_REG_RESET;
            output_data_q <= `ACIO_REG_RESET;
            pullup_control_q <= `ACIO_REG_RESET;
            standby_output_hold_enable_q <= `ACIO_STBY_RESET;
        end
        else if (wr_fire && w_lane_q && !manual_reset)
        begin
            case (aw_idx_q)
                `ACIO_IDX_DIR:
                begin
                    pin_direction_q <= w_data_q;
                end
                `ACIO_IDX_DATA:
                begin
                    output_data_q <= w_data_q;
                end
                `ACIO_IDX_PULLUP:
                begin
                    pullup_control_q <= w_data_q;
                end
                `ACIO_IDX_STBY:
                begin
                    standby_output_hold_enable_q <=
                        w_data_q[`ACIO_HOLD_BIT];
                end
                default:
                begin
                    pin_direction_q <= pin_direction_q;
                end
            endcase
        end
    end

    // Write response
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= `ACIO_RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? `ACIO_RESP_OKAY : `ACIO_RESP_DECERR;
        end
        else if (s_axi_bready)
        begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // ------------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------------

    assign s_axi_arready = !rvalid_q;
    assign rd_fire = s_axi_arvalid && !rvalid_q;
    assign ar_idx = s_axi_araddr[`ACIO_IDX_MSB:`ACIO_IDX_LSB];

    // Read decode
    always @*
    begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        case (ar_idx)
            `ACIO_IDX_DIR:
            begin
                rd_word[PINS-1:0] = `ACIO_DIR_READ;
            end
            `ACIO_IDX_READBACK:
            begin
                rd_word[PINS-1:0] = readback_q;
            end
            `ACIO_IDX_DATA:
            begin
                rd_word[PINS-1:0] = output_data_q;
            end
            `ACIO_IDX_PULLUP:
            begin
                rd_word[PINS-1:0] = pullup_control_q;
            end
            `ACIO_IDX_STBY:
            begin
                rd_word[`ACIO_HOLD_BIT] = standby_output_hold_enable_q;
            end
            default:
            begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // Read data captured at address handshake, held until taken
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `ACIO_RESP_OKAY;
        end
        else if (rd_fire)
        begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_hit ? `ACIO_RESP_OKAY : `ACIO_RESP_DECERR;
        end
        else if (s_axi_rready)
        begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

endmodule
`default_nettype wire

/* File: hdl/acio_defines.vh */
// Overview of operation
// - Direction register write-only, reads return filler
// - Direction clears on reset, hardware standby
// - Standby address pins hold or float
// - Modes 1,4,5: all pins address outputs
// - Modes 2,6: direction picks address/input
// - Modes 3,7: direction picks data/input
// - Output data register read/write, cleared likewise
// - Readback register read-only, writes ignored
// - Readback: data bit if output, pin otherwise
// - Readback tracks pins, frozen in software standby unless in hardware standby
// - Pull-up control read/write, cleared likewise
// - Pull-up when input and control bit set
// - Registers decoded on low sixteen index bits
// - Modes 1,4,5: pull-ups always off
`ifndef ACIO_DEFINES_VH
`define ACIO_DEFINES_VH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define ACIO_IDX_DIR 16'hfebb
`define ACIO_IDX_READBACK 16'hff5b
`define ACIO_IDX_DATA 16'hff6b
`define ACIO_IDX_PULLUP 16'hff72
`define ACIO_IDX_STBY 16'hff74
`define ACIO_IDX_LSB 2
`define ACIO_IDX_MSB 17

// ----------------------------------------------------------------------
// Reset values, fields and fixed read values
// ----------------------------------------------------------------------
`define ACIO_REG_RESET 8'h00
`define ACIO_STBY_RESET 1'b0
`define ACIO_HOLD_BIT 0
`define ACIO_DIR_READ 8'hff
`define ACIO_DATA_LANE 0

// ----------------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------------
`define ACIO_RESP_OKAY 2'b00
`define ACIO_RESP_DECERR 2'b11

// ----------------------------------------------------------------------
// Operating modes
// ----------------------------------------------------------------------
`define ACIO_MODE_1 3'h1
`define ACIO_MODE_2 3'h2
`define ACIO_MODE_3 3'h3
`define ACIO_MODE_4 3'h4
`define ACIO_MODE_5 3'h5
`define ACIO_MODE_6 3'h6
`define ACIO_MODE_7 3'h7

`endif

/* File: hdl/acio_sync.v */
`timescale 1ns/1ps
`default_nettype none
module acio_sync #(
    parameter WIDTH = 8
) (
    input wire aclk,
    input wire aresetn,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    // Two-stage synchroniser; first stage read only by the second
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end
        else
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule
`default_nettype wire

/* File: hdl/acio_pin_cell.v */
`timescale 1ns/1ps
`default_nettype none
module acio_pin_cell (
    input wire aclk,
    input wire aresetn,
    input wire cls_fixed,
    input wire cls_sel,
    input wire cls_gpio,
    input wire pu_allowed,
    input wire dir_bit,
    input wire data_bit,
    input wire pullup_bit,
    input wire addr_bit,
    input wire sw_standby,
    input wire hold_en,
    input wire hw_standby,
    output reg pin_out,
    output reg pin_oe,
    output reg pullup_en
);

    reg is_addr;
    reg is_gpio;
    reg oe_d;
    reg out_d;
    reg pu_d;

    // Pin function from mode class and register bits
    always @*
    begin
        is_addr = cls_fixed | (cls_sel & dir_bit);
        is_gpio = cls_gpio & dir_bit;
        out_d = is_addr ? addr_bit : data_bit;
        oe_d = is_addr | is_gpio;
        if (is_addr && sw_standby && !hold_en)
        begin
            oe_d = 1'b0;
        end
        if (hw_standby)
        begin
            oe_d = 1'b0;
        end
        pu_d = pu_allowed & ~dir_bit & pullup_bit & ~hw_standby;
    end

    // Registered pin drive, refreshed every cycle
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_out <= 1'b0;
            pin_oe <= 1'b0;
            pullup_en <= 1'b0;
        end
        else
        begin
            pin_out <= out_d;
            pin_oe <= oe_d;
            pullup_en <= pu_d;
        end
    end

endmodule
`default_nettype wire

/* File: bench/acio_props.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------------
module acio_props #(
    parameter PINS = 8,
    parameter ADDR_W = 18
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [2:0] mode,
    input wire logic hw_standby,
    input wire logic sw_standby,
    input wire logic [PINS-1:0] addr_bus,
    input wire logic [PINS-1:0] pin_out,
    input wire logic [PINS-1:0] pin_oe,
    input wire logic [PINS-1:0] pullup_en,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Mode groups, run state and a taken read
    wire fix = mode == 3'h1 || mode == 3'h4 || mode == 3'h5;
    wire sel = mode == 3'h2 || mode == 3'h6;
    wire run = !hw_standby && !sw_standby;
    wire rd = s_axi_arvalid && s_axi_arready;
    wire [15:0] ridx = s_axi_araddr[17:2];

    a_fixed_addr: assert property (
        fix && run |=> pin_oe == 8'hff && pin_out == $past(addr_bus))
        else $error("fixed mode pins not driving address");
    a_select_addr: assert property (
        sel && run |=> (pin_out & pin_oe) == ($past(addr_bus) & pin_oe))
        else $error("select mode output not address");
    a_no_pullup: assert property (
        fix |=> pullup_en == 8'h00)
        else $error("pull-up on in fixed address mode");
    a_pullup_input: assert property (
        (pullup_en & pin_oe) == 8'h00)
        else $error("pull-up on a driven pin");
    a_hw_clear: assert property (
        hw_standby |=> pin_oe == 8'h00 && pullup_en == 8'h00)
        else $error("pins active in hardware standby");
    a_read_answer: assert property (
        rd |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    a_dir_filler: assert property (
        rd && ridx == 16'hfebb |=> s_axi_rdata == 32'h000000ff)
        else $error("direction read not filler");
    a_unmapped_err: assert property (
        rd && ridx == 16'h0000 |=> s_axi_rresp == 2'b11)
        else $error("unmapped read not decode error");

    c_fixed: cover property (fix && run);
    c_select: cover property (sel && run);
    c_standby: cover property (sw_standby && fix);
endmodule

bind acio_port acio_props #(.PINS(PINS), .ADDR_W(ADDR_W)) u_props (
    .aclk, .aresetn, .mode, .hw_standby, .sw_standby, .addr_bus,
    .pin_out, .pin_oe, .pullup_en, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid
);
`default_nettype wire

/* File: bench/acio_pin_load.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Pin loads outside the port
// ----------------------------------------------------------------------
module acio_pin_load (
    input wire logic aclk,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pullup_en,
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    output logic [7:0] pin_lvl
);
    logic [7:0] flt_q = 8'h55;
    // Floating pins wander so a stale level never looks valid
    always @(posedge aclk)
        flt_q <= ~flt_q;
    // Port drive wins, then the load, then the pull-up
    assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en & (pullup_en | flt_q));
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "acio_defines.vh"
module tb_top;
    typedef struct packed {
        logic [2:0] m;
        logic [7:0] dir, dat, pu, ext, oe, out, pue, rb;
    } acio_row_t;
    logic aclk = 1'b0, aresetn = 1'b0, hw = 1'b0, mr = 1'b0, sw = 1'b0;
    logic [2:0] mode = 3'h0;
    logic [7:0] abus = 8'hc3, ext = 8'h00, p_out, p_oe, p_pu, p_lvl;
    logic [17:0] awaddr = 18'h0, araddr = 18'h0;
    logic [31:0] wdata = 32'h0, rdata;
    // Response readies stay high so back-to-back calls never toggle them
    logic awv = 1'b0, wv = 1'b0, bready = 1'b1, arv = 1'b0, rready = 1'b1;
    logic awr, wr, bv, arr, rv;
    logic [1:0] bresp, rresp;
    int n_errors = 0, cmp_count = 0;
    // Mode, dir, data, pull-up, load; then oe, out, pull-ups, readback
    acio_row_t rows [8] = '{
        '{3'h1, 8'h00, 8'h0f, 8'hff, 8'h00, 8'hff, 8'hc3, 8'h00, 8'hc3},
        '{3'h4, 8'hf0, 8'h0f, 8'hff, 8'h00, 8'hff, 8'hc3, 8'h00, 8'h03},
        '{3'h5, 8'h0f, 8'h3c, 8'hff, 8'h00, 8'hff, 8'hc3, 8'h00, 8'hcc},
        '{3'h2, 8'hf0, 8'h0f, 8'h0f, 8'ha5, 8'hf0, 8'hc0, 8'h0f, 8'h05},
        '{3'h6, 8'h0f, 8'h3c, 8'hf0, 8'h5a, 8'h0f, 8'h03, 8'hf0, 8'h5c},
        '{3'h3, 8'h33, 8'ha5, 8'hcc, 8'h0f, 8'h33, 8'h21, 8'hcc, 8'h2d},
        '{3'h7, 8'hff, 8'h96, 8'hff, 8'h00, 8'hff, 8'h96, 8'h00, 8'h96},
        '{3'h0, 8'hff, 8'h77, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h77}};

    always #50 aclk = ~aclk;

    acio_port u_dut (.aclk(aclk), .aresetn(aresetn), .mode(mode),
        .hw_standby(hw), .manual_reset(mr), .sw_standby(sw),
        .addr_bus(abus), .pin_in(p_lvl), .pin_out(p_out), .pin_oe(p_oe),
        .pullup_en(p_pu), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rv), .s_axi_rready(rready));
    acio_pin_load u_load (.aclk(aclk), .pin_out(p_out), .pin_oe(p_oe),
        .pullup_en(p_pu), .ext_val(ext), .ext_en(8'hff), .pin_lvl(p_lvl));

    // ------------------------------------------------------------------
    // Compare and bus tasks
    // ------------------------------------------------------------------
    task automatic chk8(input string nm, input logic [7:0] e, g);
        cmp_count++;
        if (g !== e)
        begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk2(input string nm, input logic [1:0] e, g);
        cmp_count++;
        if (g !== e)
        begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    // Write with both channels offered together, held until taken
    task automatic wchk(input logic [15:0] ix, input logic [7:0] d,
        input logic [1:0] er);
        logic a, w, b;
        logic [1:0] r;
        b = 1'b0;
        awaddr <= {ix, 2'b00};
        wdata <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        while (!b)
        begin
            @(negedge aclk);
            a = awv & awr;
            w = wv & wr;
            b = bv;
            r = bresp;
            @(posedge aclk);
            if (a) awv <= 1'b0;
            if (w) wv <= 1'b0;
        end
        chk2("bresp", er, r);
    endtask
    // Read held until taken; data taken at the answer edge
    task automatic rchk(input logic [15:0] ix, input logic [7:0] e,
        input logic [1:0] er);
        logic a, v;
        logic [7:0] q;
        logic [1:0] r;
        v = 1'b0;
        araddr <= {ix, 2'b00};
        arv <= 1'b1;
        while (!v)
        begin
            @(negedge aclk);
            a = arv & arr;
            v = rv;
            q = rdata[7:0];
            r = rresp;
            @(posedge aclk);
            if (a) arv <= 1'b0;
        end
        chk8("rdata", e, q);
        chk2("rresp", er, r);
    endtask
    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(`ACIO_IDX_DATA, 8'h00, 2'b00);
        rchk(`ACIO_IDX_PULLUP, 8'h00, 2'b00);
        rchk(`ACIO_IDX_DIR, 8'hff, 2'b00);
        rchk(16'h0000, 8'h00, 2'b11);
        wchk(16'h0000, 8'h5a, 2'b11);
        foreach (rows[i])
        begin
            mode <= rows[i].m;
            ext <= rows[i].ext;
            wchk(`ACIO_IDX_DIR, rows[i].dir, 2'b00);
            wchk(`ACIO_IDX_DATA, rows[i].dat, 2'b00);
            wchk(`ACIO_IDX_PULLUP, rows[i].pu, 2'b00);
            repeat (3) @(posedge aclk);
            @(negedge aclk);
            chk8("pin_oe", rows[i].oe, p_oe);
            chk8("pin_out", rows[i].out, p_out & p_oe);
            chk8("pullup_en", rows[i].pue, p_pu);
            @(posedge aclk);
            rchk(`ACIO_IDX_READBACK, rows[i].rb, 2'b00);
        end
        wchk(`ACIO_IDX_READBACK, 8'hff, 2'b00);
        rchk(`ACIO_IDX_DATA, 8'h77, 2'b00);
        mr <= 1'b1;
        repeat (2) @(posedge aclk);
        mr <= 1'b0;
        rchk(`ACIO_IDX_DATA, 8'h77, 2'b00);
        rchk(`ACIO_IDX_PULLUP, 8'hff, 2'b00);
        hw <= 1'b1;
        repeat (2) @(posedge aclk);
        hw <= 1'b0;
        rchk(`ACIO_IDX_DATA, 8'h00, 2'b00);
        rchk(`ACIO_IDX_PULLUP, 8'h00, 2'b00);
        // Standby with address pins floated, then held
        mode <= 3'h1;
        wchk(`ACIO_IDX_STBY, 8'h00, 2'b00);
        sw <= 1'b1;
        repeat (2) @(posedge aclk);
        @(negedge aclk);
        chk8("pin_oe", 8'h00, p_oe);
        @(posedge aclk);
        sw <= 1'b0;
        wchk(`ACIO_IDX_STBY, 8'h01, 2'b00);
        sw <= 1'b1;
        repeat (2) @(posedge aclk);
        abus <= 8'h3c;
        repeat (2) @(negedge aclk);
        chk8("pin_oe", 8'hff, p_oe);
        chk8("pin_out", 8'hc3, p_out);
        @(posedge aclk);
        sw <= 1'b0;
        // Readback frozen through standby
        mode <= 3'h3;
        ext <= 8'h11;
        repeat (5) @(posedge aclk);
        sw <= 1'b1;
        @(posedge aclk);
        ext <= 8'h22;
        repeat (5) @(posedge aclk);
        rchk(`ACIO_IDX_READBACK, 8'h11, 2'b00);
        sw <= 1'b0;
        repeat (5) @(posedge aclk);
        rchk(`ACIO_IDX_READBACK, 8'h22, 2'b00);
        test_done;
    end
    // Watchdog against a hung handshake
    initial
    begin
        repeat (5000) @(posedge aclk);
        n_errors++;
        test_done;
    end
endmodule
`default_nettype wire
